// [logic/ctdt_defines.svh]
// Register offsets, field positions and reset values of the dual timer
`ifndef CTDT_DEFINES_SVH
`define CTDT_DEFINES_SVH
`define CTDT_OFS_CTRL_LO  4'h0
`define CTDT_OFS_CTRL_HI  4'h1
`define CTDT_OFS_CMP_LO   4'h2
`define CTDT_OFS_CMP_HI   4'h3
`define CTDT_OFS_CFG      4'h4
`define CTDT_OFS_STATUS   4'h5
`define CTDT_OFS_MASK     4'h6
`define CTDT_OFS_CNT_LO   4'h7
`define CTDT_OFS_CNT_HI   4'h8
`define CTDT_FF_BIT       7
`define CTDT_CK_MSB       6
`define CTDT_CK_LSB       4
`define CTDT_START_BIT    3
`define CTDT_MODE_MSB     2
`define CTDT_MODE_LSB     0
`define CTDT_CFG_DIVSRC   0
`define CTDT_CTRL_RST     8'h00
`define CTDT_CMP_RST      8'hff
`define CTDT_SRC_PIN      3'h7
`define CTDT_SRC_FC       3'h6
`define CTDT_FC_DIV_W     11
`define CTDT_FS_DIV_W     3
`endif

// [logic/ctdt_pkg.sv]
// Types shared by the dual timer modules
package ctdt_pkg;
    typedef enum logic [2:0] {
        CTDT_TIMER8  = 3'h0,
        CTDT_DIVOUT8 = 3'h1,
        CTDT_PWM8    = 3'h2,
        CTDT_CASCLO  = 3'h3,
        CTDT_TIMER16 = 3'h4,
        CTDT_WARMUP  = 3'h5,
        CTDT_PWM16   = 3'h6,
        CTDT_PPG16   = 3'h7
    } ctdt_mode_t;
    typedef logic [6:0] ctdt_taps_t;
endpackage : ctdt_pkg

// [logic/ctdt_cnt_if.sv]
// Control and status lines between the timer core and one byte counter
`timescale 1ns/1ps
interface ctdt_cnt_if #(parameter int WIDTH = 8);
    logic             tick;
    logic             clear;
    logic [WIDTH-1:0] count;
    logic             wrap;
    modport ctl (output tick, output clear, input count, input wrap);
    modport cnt (input tick, input clear, output count, output wrap);
endinterface : ctdt_cnt_if

// [logic/ctdt_counter.sv]
// One byte-wide up-counter with synchronous clear and carry out
`timescale 1ns/1ps
module ctdt_counter #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Core side
    ctdt_cnt_if.cnt  port
);
    import ctdt_pkg::*;

    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;

    initial begin
        if (WIDTH < 1) $error("ctdt_counter: WIDTH must be at least 1");
    end

    // Clear beats the tick so a match restarts from zero
    always_comb begin
        count_nxt = count_r;
        if (port.clear) begin
            count_nxt = '0;
        end else if (port.tick) begin
            count_nxt = WIDTH'(count_r + 1'b1);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    // Carry is a pulse that feeds the upper byte when cascaded
    assign port.count = count_r;
    assign port.wrap  = port.tick && (&count_r);

    a_count_steady: assert property (@(posedge clk) disable iff (reset)
        (!port.tick && !port.clear) |=> (count_r == $past(count_r)))
        else $error("counter moved without tick");
endmodule : ctdt_counter

// [logic/ctdt_prescaler.sv]
// Prescaler producing one-cycle tick pulses for every source clock tap
`timescale 1ns/1ps
`include "ctdt_defines.svh"
module ctdt_prescaler #(
    parameter int DIV_W = `CTDT_FC_DIV_W
) (
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            reset,
    // Sources
    input  wire logic            fsClkIn,
    input  wire logic            slowTapSel,
    // Taps indexed by clock select code
    output ctdt_pkg::ctdt_taps_t taps
);
    import ctdt_pkg::*;

    logic [DIV_W-1:0]            fcDiv_r;
    logic [`CTDT_FS_DIV_W-1:0]   fsDiv_r;
    logic                        fsMeta_r;
    logic                        fsSync_r;
    logic                        fsPrev_r;
    logic                        fsRise;
    ctdt_taps_t                  taps_r;
    ctdt_taps_t                  taps_nxt;

    initial begin
        if (DIV_W < `CTDT_FC_DIV_W) $error("ctdt_prescaler: DIV_W too small for the slowest tap");
    end

    // Low clock is asynchronous, so only its synchronised edge is used
    assign fsRise = fsSync_r && !fsPrev_r;

    always_comb begin
        taps_nxt    = '0;
        taps_nxt[0] = slowTapSel ? (fsRise && (&fsDiv_r)) : (&fcDiv_r[10:0]);
        taps_nxt[1] = &fcDiv_r[6:0];
        taps_nxt[2] = &fcDiv_r[4:0];
        taps_nxt[3] = &fcDiv_r[2:0];
        taps_nxt[4] = fsRise;
        taps_nxt[5] = fcDiv_r[0];
        taps_nxt[6] = 1'b1;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fcDiv_r  <= '0;
            fsDiv_r  <= '0;
            fsMeta_r <= 1'b0;
            fsSync_r <= 1'b0;
            fsPrev_r <= 1'b0;
            taps_r   <= '0;
        end else begin
            fcDiv_r  <= DIV_W'(fcDiv_r + 1'b1);
            fsDiv_r  <= fsRise ? `CTDT_FS_DIV_W'(fsDiv_r + 1'b1) : fsDiv_r;
            fsMeta_r <= fsClkIn;
            fsSync_r <= fsMeta_r;
            fsPrev_r <= fsSync_r;
            taps_r   <= taps_nxt;
        end
    end

    assign taps = taps_r;
endmodule : ctdt_prescaler

// [logic/ctdt_timer.sv]
// Cascadable dual 8-bit timer/event counter with register port and match interrupt
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "ctdt_defines.svh"

// Behaviour
// - When cascaded, the count clock comes from the lower clock select and the upper select is ignored.
// - When cascaded, run/stop and the flip-flop start level come from the upper start and flip-flop bits.
// - In 8-bit timer mode the counter counts internal ticks and on a compare match raises the request and clears.
// - The compare value is not double buffered, so a write acts at once and should wait for a stopped timer.
// - In 8-bit event mode the counter counts falling edges of its input pin, matching and clearing as a timer.
// - With the upper timer in a 16-bit mode the upper byte is clocked by the lower byte overflow.
module ctdt_timer (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Register port
    input  wire logic [3:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output logic      [7:0] regRdData,
    // Clock sources and state
    input  wire logic       fsClkIn,
    input  wire logic       slowState,
    // Event input pins
    input  wire logic       eventPinLower,
    input  wire logic       eventPinUpper,
    // Requests and pins
    output logic            matchIrq,
    output logic            matchPulseLower,
    output logic            matchPulseUpper,
    output logic            divOutLower,
    output logic            divOutUpper
);
    import ctdt_pkg::*;

    ctdt_cnt_if #(.WIDTH(8)) lowIf ();
    ctdt_cnt_if #(.WIDTH(8)) upIf ();

    logic [7:0] ctrlLower_r, ctrlLower_nxt;
    logic [7:0] ctrlUpper_r, ctrlUpper_nxt;
    logic [7:0] cmpLower_r, cmpLower_nxt;
    logic [7:0] cmpUpper_r, cmpUpper_nxt;
    logic       divSrc_r, divSrc_nxt;
    logic [1:0] status_r, status_nxt;
    logic [1:0] mask_r, mask_nxt;
    logic [7:0] rdData_r, rdData_nxt;
    logic       irq_r, irq_nxt;
    logic       pulseLo_r, pulseUp_r;
    logic       ffLower_r, ffLower_nxt;
    logic       ffUpper_r, ffUpper_nxt;
    logic       divLo_r, divUp_r;
    logic [1:0] pinMeta_r, pinSync_r, pinPrev_r;
    logic [1:0] pinIn, pinFall;
    ctdt_taps_t taps;
    ctdt_mode_t upperMode;
    logic       cascade;
    logic       runLower, runUpper;
    logic [2:0] lowerSel, upperSel;
    logic       lTick, uTick;
    logic [15:0] next16;
    logic       hitLower8, hitUpper8, hit16;
    logic       matchL, matchU;

    // Shared prescaler; tap 0 falls back to fs/2^3 in the slow states
    ctdt_prescaler #(.DIV_W(`CTDT_FC_DIV_W)) u_prescaler (
        .clk        (clk),
        .reset      (reset),
        .fsClkIn    (fsClkIn),
        .slowTapSel (divSrc_r || slowState),
        .taps       (taps)
    );

    ctdt_counter #(.WIDTH(8)) u_cnt_lower (
        .clk   (clk),
        .reset (reset),
        .port  (lowIf.cnt)
    );

    ctdt_counter #(.WIDTH(8)) u_cnt_upper (
        .clk   (clk),
        .reset (reset),
        .port  (upIf.cnt)
    );

    // Event pins are asynchronous: two flops, then a third for the edge
    assign pinIn = {eventPinUpper, eventPinLower};
    generate
        for (genvar i = 0; i < 2; i++) begin : g_pin
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    pinMeta_r[i] <= 1'b1;
                    pinSync_r[i] <= 1'b1;
                    pinPrev_r[i] <= 1'b1;
                end else begin
                    pinMeta_r[i] <= pinIn[i];
                    pinSync_r[i] <= pinMeta_r[i];
                    pinPrev_r[i] <= pinSync_r[i];
                end
            end
            // Phases shorter than two machine cycles may be missed
            assign pinFall[i] = pinPrev_r[i] && !pinSync_r[i];
        end
    endgenerate

    // Source selection: taps by code, pin falling edge for the top code
    function automatic logic srcTick(input logic [2:0] sel, input ctdt_taps_t tp, input logic fall);
        srcTick = (sel == `CTDT_SRC_PIN) ? fall : tp[sel];
    endfunction : srcTick

    // Cascade follows the upper mode alone; upper byte runs off lower carry
    assign upperMode = ctdt_mode_t'(ctrlUpper_r[`CTDT_MODE_MSB:`CTDT_MODE_LSB]);
    assign cascade   = upperMode[`CTDT_MODE_MSB];
    assign lowerSel  = ctrlLower_r[`CTDT_CK_MSB:`CTDT_CK_LSB];
    assign upperSel  = ctrlUpper_r[`CTDT_CK_MSB:`CTDT_CK_LSB];
    assign runUpper  = ctrlUpper_r[`CTDT_START_BIT];
    assign runLower  = cascade ? runUpper : ctrlLower_r[`CTDT_START_BIT];
    assign lTick     = runLower && srcTick(lowerSel, taps, pinFall[0]);
    assign uTick     = cascade ? lowIf.wrap : (runUpper && srcTick(upperSel, taps, pinFall[1]));

    // Compare against the value the counter is about to take; compare
    // registers are read live so a write takes effect on the next tick
    assign next16    = 16'({upIf.count, lowIf.count} + 16'h0001);
    assign hitLower8 = !cascade && lTick && (8'(lowIf.count + 8'h01) == cmpLower_r);
    assign hitUpper8 = !cascade && uTick && (8'(upIf.count + 8'h01) == cmpUpper_r);
    assign hit16     = cascade && lTick && (next16 == {cmpUpper_r, cmpLower_r});
    assign matchL    = hitLower8;
    assign matchU    = hitUpper8 || hit16;

    // Stopping clears the count, as does a match
    assign lowIf.tick  = lTick;
    assign lowIf.clear = !runLower || hitLower8 || hit16;
    assign upIf.tick   = uTick;
    assign upIf.clear  = !runUpper || hitUpper8 || hit16;

    // Register writes; status is write-one-to-clear and a new match wins
    always_comb begin
        ctrlLower_nxt = ctrlLower_r;
        ctrlUpper_nxt = ctrlUpper_r;
        cmpLower_nxt  = cmpLower_r;
        cmpUpper_nxt  = cmpUpper_r;
        divSrc_nxt    = divSrc_r;
        mask_nxt      = mask_r;
        status_nxt    = status_r;
        if (regWr) begin
            unique case (regAddr)
                `CTDT_OFS_CTRL_LO: ctrlLower_nxt = regWrData;
                `CTDT_OFS_CTRL_HI: ctrlUpper_nxt = regWrData;
                `CTDT_OFS_CMP_LO:  cmpLower_nxt  = regWrData;
                `CTDT_OFS_CMP_HI:  cmpUpper_nxt  = regWrData;
                `CTDT_OFS_CFG:     divSrc_nxt    = regWrData[`CTDT_CFG_DIVSRC];
                `CTDT_OFS_STATUS:  status_nxt    = status_r & ~regWrData[1:0];
                `CTDT_OFS_MASK:    mask_nxt      = regWrData[1:0];
                default:           ;
            endcase
        end
        status_nxt = status_nxt | {matchU, matchL};
    end

    // Read data stand in the cycle after the strobe; holes read zero
    always_comb begin
        rdData_nxt = 8'h00;
        if (regRd) begin
            unique case (regAddr)
                `CTDT_OFS_CTRL_LO: rdData_nxt = ctrlLower_r;
                `CTDT_OFS_CTRL_HI: rdData_nxt = ctrlUpper_r;
                `CTDT_OFS_CMP_LO:  rdData_nxt = cmpLower_r;
                `CTDT_OFS_CMP_HI:  rdData_nxt = cmpUpper_r;
                `CTDT_OFS_CFG:     rdData_nxt = {7'h00, divSrc_r};
                `CTDT_OFS_STATUS:  rdData_nxt = {6'h00, status_r};
                `CTDT_OFS_MASK:    rdData_nxt = {6'h00, mask_r};
                `CTDT_OFS_CNT_LO:  rdData_nxt = lowIf.count;
                `CTDT_OFS_CNT_HI:  rdData_nxt = upIf.count;
                default:           rdData_nxt = 8'h00;
            endcase
        end
    end

    // Output flip-flops load their start level while stopped and hold while
    // running; toggling belongs to the output modes, not built here
    always_comb begin
        irq_nxt     = |(status_nxt & mask_nxt);
        ffUpper_nxt = runUpper ? ffUpper_r : ctrlUpper_r[`CTDT_FF_BIT];
        ffLower_nxt = ffLower_r;
        if (!runLower) begin
            ffLower_nxt = cascade ? ctrlUpper_r[`CTDT_FF_BIT] : ctrlLower_r[`CTDT_FF_BIT];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrlLower_r <= `CTDT_CTRL_RST;
            ctrlUpper_r <= `CTDT_CTRL_RST;
            cmpLower_r  <= `CTDT_CMP_RST;
            cmpUpper_r  <= `CTDT_CMP_RST;
            divSrc_r    <= 1'b0;
            status_r    <= 2'h0;
            mask_r      <= 2'h0;
            rdData_r    <= 8'h00;
            irq_r       <= 1'b0;
            pulseLo_r   <= 1'b0;
            pulseUp_r   <= 1'b0;
            ffLower_r   <= 1'b0;
            ffUpper_r   <= 1'b0;
            divLo_r     <= 1'b1;
            divUp_r     <= 1'b1;
        end else begin
            ctrlLower_r <= ctrlLower_nxt;
            ctrlUpper_r <= ctrlUpper_nxt;
            cmpLower_r  <= cmpLower_nxt;
            cmpUpper_r  <= cmpUpper_nxt;
            divSrc_r    <= divSrc_nxt;
            status_r    <= status_nxt;
            mask_r      <= mask_nxt;
            rdData_r    <= rdData_nxt;
            irq_r       <= irq_nxt;
            pulseLo_r   <= matchL;
            pulseUp_r   <= matchU;
            ffLower_r   <= ffLower_nxt;
            ffUpper_r   <= ffUpper_nxt;
            divLo_r     <= !ffLower_nxt;
            divUp_r     <= !ffUpper_nxt;
        end
    end

    assign regRdData       = rdData_r;
    assign matchIrq        = irq_r;
    assign matchPulseLower = pulseLo_r;
    assign matchPulseUpper = pulseUp_r;
    assign divOutLower     = divLo_r;
    assign divOutUpper     = divUp_r;

    // Checks on the counting and request path
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence sLowerTimerHit;
        !cascade && runLower && (lowerSel != `CTDT_SRC_PIN) && lTick
            && (8'(lowIf.count + 8'h01) == cmpLower_r);
    endsequence

    sequence sLowerCleared;
        (lowIf.count == 8'h00) && pulseLo_r && status_r[0];
    endsequence

    a_timer_match_clear: assert property (sLowerTimerHit |=> sLowerCleared)
        else $error("timer match did not clear and request");

    a_event_count_up: assert property ((!cascade && runLower && (lowerSel == `CTDT_SRC_PIN)
        && pinFall[0] && !hitLower8) |=> (lowIf.count == 8'($past(lowIf.count) + 8'h01)))
        else $error("event edge not counted");

    a_cascade_clk_src: assert property ((cascade && runUpper && (lowerSel != `CTDT_SRC_PIN))
        |-> (lTick == taps[lowerSel]))
        else $error("cascade not clocked by lower select");

    a_cascade_run_stop: assert property ((cascade && !ctrlUpper_r[`CTDT_START_BIT]) |=>
        ((lowIf.count == 8'h00) && (upIf.count == 8'h00)))
        else $error("cascade ran without upper start");

    a_upper_carry_clk: assert property (cascade |-> (uTick == lowIf.wrap))
        else $error("upper byte not clocked by lower carry");

    a_cmp_write_live: assert property ((regWr && (regAddr == `CTDT_OFS_CMP_LO)) |=>
        (cmpLower_r == $past(regWrData)))
        else $error("compare write not effective at once");

    a_match_pulse_once: assert property ((pulseUp_r && !$past(matchU, 2)) |=> !pulseUp_r or $past(matchU))
        else $error("match pulse stretched");

    a_irq_follows: assert property (matchIrq == |(status_r & mask_r))
        else $error("interrupt does not follow masked status");

    a_status_sticky: assert property ((status_r[1] && !(regWr && (regAddr == `CTDT_OFS_STATUS)
        && regWrData[1])) |=> status_r[1])
        else $error("status bit lost");
endmodule : ctdt_timer

// [verification/ctdt_event_src.sv]
// Model of the external pulse source that drives one event input pin
`timescale 1ns/1ps
module ctdt_event_src #(
    parameter int HOLD = 2
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Burst request
    input  wire logic       go,
    input  wire logic [7:0] edges,
    // Pin and status
    output logic            pin,
    output logic            busy
);
    int phase;
    int left;

    // Pin idles high like a pulled-up input, so a released line never fakes an edge
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            pin   <= 1'b1;
            busy  <= 1'b0;
            phase <= 0;
            left  <= 0;
        end else if (!busy) begin
            if (go) begin
                busy  <= 1'b1;
                left  <= edges;
                phase <= 0;
            end
        end else if (phase < HOLD - 1) begin
            phase <= phase + 1;
        end else begin
            phase <= 0;
            if (pin) begin
                if (left == 0) busy <= 1'b0;
                else pin <= 1'b0;
            end else begin
                pin  <= 1'b1;
                left <= left - 1;
            end
        end
    end
endmodule : ctdt_event_src

// [verification/tb_top.sv]
// Self-checking bench for the dual timer through its register port
`timescale 1ns/1ps
module tb_top;
    logic       clk;
    logic       reset;
    logic [3:0] regAddr;
    logic [7:0] regWrData;
    logic       regWr;
    logic       regRd;
    logic [7:0] regRdData;
    logic       fsClkIn;
    logic       slowState;
    logic       pinLo;
    logic       pinHi;
    logic       matchIrq;
    logic       matchPulseLower;
    logic       matchPulseUpper;
    logic       divOutLower;
    logic       divOutUpper;
    logic       goEv;
    logic       busyLo;
    logic       busyHi;
    int         failures;
    int         samples_checked;
    int         n;
    int         cntLo;
    int         cntHi;

    ctdt_timer i_ctdt_timer (
        .clk(clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .fsClkIn(fsClkIn), .slowState(slowState),
        .eventPinLower(pinLo), .eventPinUpper(pinHi), .matchIrq(matchIrq),
        .matchPulseLower(matchPulseLower), .matchPulseUpper(matchPulseUpper),
        .divOutLower(divOutLower), .divOutUpper(divOutUpper));

    // A fast and a slower source, so both input paths see legal but different timing
    ctdt_event_src #(.HOLD(2)) i_ctdt_event_src_lo (
        .clk(clk), .reset(reset), .go(goEv), .edges(8'h07), .pin(pinLo), .busy(busyLo));
    ctdt_event_src #(.HOLD(3)) i_ctdt_event_src_hi (
        .clk(clk), .reset(reset), .go(goEv), .edges(8'h07), .pin(pinHi), .busy(busyHi));

    // System clock and a low-frequency clock of 32 cycles, offset from the system edges
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        fsClkIn = 1'b0;
        #3;
        forever #160 fsClkIn = ~fsClkIn;
    end

    // Match pulse tallies for the event counter tests
    always @(posedge clk) begin
        if (matchPulseLower === 1'b1) cntLo <= cntLo + 1;
        if (matchPulseUpper === 1'b1) cntHi <= cntHi + 1;
    end

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Strobe tasks let an edge pass first, so a strobe is never lowered and raised in one step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr   <= a;
        regWrData <= d;
        regWr     <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        chk($sformatf("reg%h", a), {8'h00, regRdData}, {8'h00, exp});
    endtask : rd

    task automatic wait_pulse(input bit hi, output int cyc);
        cyc = 0;
        do begin
            @(posedge clk);
            #1;
            cyc++;
        end while ((hi ? matchPulseUpper : matchPulseLower) !== 1'b1 && cyc < 3000);
        if (cyc >= 3000) failures++;
    endtask : wait_pulse

    // Spacing between two match pulses; the first pulse after a change may be left over from the old setting
    task automatic period(input bit hi, input int exp);
        wait_pulse(hi, n);
        wait_pulse(hi, n);
        wait_pulse(hi, n);
        chk(hi ? "periodHi" : "periodLo", n[15:0], exp[15:0]);
    endtask : period

    task automatic final_report;
        if (failures == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    // Watchdog at 30k cycles, well beyond the roughly 12k cycles the tests need
    initial begin
        #300000;
        failures++;
        final_report();
    end

    initial begin
        reset = 1'b1;
        regAddr = 4'h0;
        regWrData = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        slowState = 1'b0;
        goEv = 1'b0;
        failures = 0;
        samples_checked = 0;
        cntLo = 0;
        cntHi = 0;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        // Reset values, unmapped index and read-only counts
        chk("divOutLower", {15'h0000, divOutLower}, 16'h0001);
        chk("divOutUpper", {15'h0000, divOutUpper}, 16'h0001);
        rd(4'h0, 8'h00);
        rd(4'h1, 8'h00);
        rd(4'h2, 8'hff);
        rd(4'h3, 8'hff);
        rd(4'h4, 8'h00);
        rd(4'h5, 8'h00);
        rd(4'h6, 8'h00);
        wr(4'h7, 8'h55);
        rd(4'h7, 8'h00);
        rd(4'h8, 8'h00);
        wr(4'hf, 8'h12);
        rd(4'hf, 8'h00);
        // Timer taps fc/8, fc/32 and fc/128 with compare 3; the fc and fc/2 taps (codes 6 and 5) are not exercised here
        wr(4'h2, 8'h03);
        wr(4'h0, 8'h38);
        period(1'b0, 24);
        wr(4'h0, 8'h28);
        period(1'b0, 96);
        wr(4'h0, 8'h18);
        period(1'b0, 384);
        // Slow state forces tap 0 to fs/8, as does the prescaler source bit; stop first so the count restarts
        wr(4'h0, 8'h00);
        wr(4'h2, 8'h01);
        slowState <= 1'b1;
        wr(4'h0, 8'h08);
        period(1'b0, 256);
        slowState <= 1'b0;
        wr(4'h4, 8'h01);
        period(1'b0, 256);
        wr(4'h2, 8'h02);
        wr(4'h0, 8'h28);
        period(1'b0, 64);
        // Sticky status, mask and write-one-to-clear
        wr(4'h0, 8'h00);
        rd(4'h5, 8'h01);
        chk("irqMasked", {15'h0000, matchIrq}, 16'h0000);
        wr(4'h6, 8'h01);
        #1;
        chk("irqOn", {15'h0000, matchIrq}, 16'h0001);
        wr(4'h5, 8'h01);
        rd(4'h5, 8'h00);
        chk("irqOff", {15'h0000, matchIrq}, 16'h0000);
        // Compare rewrite while running acts at once: 30 cycles to the new match instead of 200 ticks
        wr(4'h2, 8'hc8);
        wr(4'h0, 8'h38);
        wait_pulse(1'b0, n);
        wr(4'h2, 8'h04);
        wait_pulse(1'b0, n);
        chk("liveCmp", n[15:0], 16'h001e);
        // Both pins as 8-bit event counters, compares 2 and 3, seven edges each
        wr(4'h0, 8'h00);
        wr(4'h2, 8'h02);
        wr(4'h3, 8'h03);
        wr(4'h0, 8'h78);
        wr(4'h1, 8'h78);
        cntLo = 0;
        cntHi = 0;
        @(posedge clk);
        goEv <= 1'b1;
        @(posedge clk);
        goEv <= 1'b0;
        repeat (2) @(posedge clk);
        n = 0;
        while ((busyLo || busyHi) && n < 200) begin
            @(posedge clk);
            n++;
        end
        chk("evDone", {15'h0000, busyLo || busyHi}, 16'h0000);
        repeat (8) @(posedge clk);
        chk("evPulsesLo", cntLo[15:0], 16'h0003);
        chk("evPulsesHi", cntHi[15:0], 16'h0002);
        rd(4'h7, 8'h01);
        rd(4'h8, 8'h01);
        // Cascade: lower select fc/8 with lower start 0, upper select names the idle pin and is ignored
        wr(4'h0, 8'h00);
        wr(4'h1, 8'h00);
        wr(4'h2, 8'h02);
        wr(4'h3, 8'h01);
        wr(4'h0, 8'h33);
        wr(4'h1, 8'h7c);
        period(1'b1, 2064);
        wr(4'h1, 8'h04);
        rd(4'h7, 8'h00);
        rd(4'h8, 8'h00);
        // Only timer and event modes were programmed, so pulse-width, pulse-generator and warm-up limits stay unused
        chk("divOutLower", {15'h0000, divOutLower}, 16'h0001);
        chk("divOutUpper", {15'h0000, divOutUpper}, 16'h0001);
        final_report();
    end
endmodule : tb_top
